// *** logic/irp_consts.svh ***
// Offsets, field positions, reset values and counts for the interrupt router.
// Assumes a byte-addressed APB slave window of 256 bytes.
`ifndef IRP_CONSTS_SVH
`define IRP_CONSTS_SVH
`define IRP_NUM_DEST 8
`define IRP_NUM_SRC 8
`define IRP_NUM_LINK 4
`define IRP_OFS_EVT_PRIMARY 8'h00
`define IRP_OFS_PORT_ERR 8'h04
`define IRP_OFS_RESET_EVT 8'h08
`define IRP_BANK_DECODE 3'h1
`define IRP_BANK_PACING 3'h2
`define IRP_LSB_MULTICAST 0
`define IRP_LSB_PORT_WRITE 4
`define IRP_LSB_LOGIC_ERR 8
`define IRP_LSB_DEV_RESET 0
`define IRP_SRC_MULTICAST 0
`define IRP_SRC_PORT_WRITE 1
`define IRP_SRC_LOGIC_ERR 2
`define IRP_SRC_LINK0 3
`define IRP_SRC_DEV_RESET 7
`define IRP_DEC_MULTICAST 0
`define IRP_DEC_PORT_WRITE 1
`define IRP_DEC_LOGIC_ERR 2
`define IRP_DEC_LINK0 8
`define IRP_DEC_DEV_RESET 16
`define IRP_ROUTE_RST 4'h0
`define IRP_PACE_RST 32'h0000_0000
`endif

// *** logic/irp_pace_if.sv ***
// Link between the router and one pacing counter.
// Assumes both ends share the router clock.
`timescale 1ns/1ps
interface irp_pace_if;
   logic load;
   logic [31:0] load_value;
   logic pending;
   logic [31:0] count;
   logic pulse;
   modport ctl(output load, output load_value, output pending, input count, input pulse);
   modport pacer(input load, input load_value, input pending, output count, output pulse);
endinterface

// *** logic/irp_pacer.sv ***
// One destination's pulse pacing down-counter.
// Assumes a synchronised active-low reset and a one-cycle load strobe.
`timescale 1ns/1ps
`include "irp_consts.svh"
module irp_pacer import irp_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_n_in,
   irp_pace_if.pacer pace
);
   irp_pacer_state_t st;
   irp_pacer_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (pace.load) begin
         next_st.count = pace.load_value;
         next_st.armed = 1'b1;
      end else if (st.count != 32'h0) begin
         next_st.count = st.count - 32'h1;
      end else if (st.armed && pace.pending) begin
         next_st.pulse = 1'b1;
         next_st.armed = 1'b0;
      end
   end

   // Armed from reset: the reset count of zero counts as an expired write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '{count: `IRP_PACE_RST, armed: 1'b1, pulse: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign pace.count = st.count;
   assign pace.pulse = st.pulse;

   a_reload_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      pace.load |=> st.count == $past(pace.load_value)) else $error("pacing counter did not reload");
   a_pulse_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(st.pulse) |-> $past(st.count) == 32'h0 && $past(pace.pending) && $past(st.armed) && !$past(pace.load))
      else $error("pulse without expired armed count");
   a_one_per_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st.pulse && !$past(pace.load) |-> !st.armed ##1 !st.pulse) else $error("second pulse without reload");
   a_zero_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (pace.load && pace.load_value == 32'h0) ##1 (pace.pending && !pace.load) |=> st.pulse)
      else $error("zero write did not allow immediate pulse");
endmodule

// *** logic/irp_pkg.sv ***
// Types shared by the interrupt router and its pacing counters.
// Assumes nothing beyond the constants header.
package irp_pkg;
   typedef logic [3:0] irp_route_t;

   typedef struct packed {
      irp_route_t logical_error_capture_route;
      irp_route_t port_write_in_route;
      irp_route_t multicast_symbol_route;
      irp_route_t [3:0] link_error_route;
      irp_route_t device_reset_route;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] pulse;
   } irp_top_state_t;

   typedef struct packed {
      logic [31:0] count;
      logic armed;
      logic pulse;
   } irp_pacer_state_t;
endpackage

// *** logic/irp_top.sv ***
// Interrupt routing, status decode and pulse pacing for eight destinations.
// Assumes an APB master on sys_clk_in and level condition bits synchronous to it.
`timescale 1ns/1ps
`include "irp_consts.svh"
module irp_top import irp_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [7:0] condition_status_bits_in,
   output logic [7:0] physical_destination_out
);
   logic rst_meta;
   logic rst_sync_n;
   irp_top_state_t st;
   irp_top_state_t next_st;
   logic [31:0] destination_decode_bits [`IRP_NUM_DEST];
   logic [31:0] pace_count [`IRP_NUM_DEST];
   logic [7:0] pace_pulse;
   logic setup_phase;
   logic wr_commit;
   logic [2:0] bank;
   logic [2:0] word_sel;
   logic aligned;
   logic [2:0] wr_dest;
   logic pace_hit;

   // Release reset through two flops so every flop leaves reset on one edge
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   assign setup_phase = psel_in && !penable_in;
   // Writes land only at the edge where pready is seen high
   assign wr_commit = psel_in && penable_in && pwrite_in && st.pready;
   assign bank = paddr_in[7:5];
   assign word_sel = paddr_in[4:2];
   assign aligned = (paddr_in[1:0] == 2'h0);
   assign wr_dest = word_sel;
   assign pace_hit = wr_commit && aligned && (bank == `IRP_BANK_PACING);

   function automatic logic routed(input irp_route_t field, input int dest);
      routed = (field == 4'(dest));
   endfunction

   always_comb begin
      for (int d = 0; d < `IRP_NUM_DEST; d++) begin
         destination_decode_bits[d] = 32'h0;
         destination_decode_bits[d][`IRP_DEC_MULTICAST] =
            condition_status_bits_in[`IRP_SRC_MULTICAST] && routed(st.multicast_symbol_route, d);
         destination_decode_bits[d][`IRP_DEC_PORT_WRITE] =
            condition_status_bits_in[`IRP_SRC_PORT_WRITE] && routed(st.port_write_in_route, d);
         destination_decode_bits[d][`IRP_DEC_LOGIC_ERR] =
            condition_status_bits_in[`IRP_SRC_LOGIC_ERR] && routed(st.logical_error_capture_route, d);
         for (int p = 0; p < `IRP_NUM_LINK; p++) begin
            destination_decode_bits[d][`IRP_DEC_LINK0 + p] =
               condition_status_bits_in[`IRP_SRC_LINK0 + p] && routed(st.link_error_route[p], d);
         end
         destination_decode_bits[d][`IRP_DEC_DEV_RESET] =
            condition_status_bits_in[`IRP_SRC_DEV_RESET] && routed(st.device_reset_route, d);
      end
   end

   genvar g;
   generate
      for (g = 0; g < `IRP_NUM_DEST; g++) begin : gen_pace
         irp_pace_if pif();
         assign pif.load = pace_hit && (wr_dest == 3'(g));
         assign pif.load_value = pwdata_in;
         assign pif.pending = |destination_decode_bits[g];
         assign pace_count[g] = pif.count;
         assign pace_pulse[g] = pif.pulse;
         irp_pacer u_pacer (
            .clk_in(sys_clk_in),
            .rst_n_in(rst_sync_n),
            .pace(pif)
         );
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.pready = setup_phase;
      next_st.pulse = pace_pulse;
      if (setup_phase) begin
         next_st.prdata = 32'h0;
         next_st.pslverr = 1'b0;
         if (!aligned) begin
            next_st.pslverr = 1'b1;
         end else if (bank == `IRP_BANK_DECODE) begin
            next_st.prdata = pwrite_in ? 32'h0 : destination_decode_bits[word_sel];
         end else if (bank == `IRP_BANK_PACING) begin
            next_st.prdata = pwrite_in ? 32'h0 : pace_count[word_sel];
         end else if (paddr_in == `IRP_OFS_EVT_PRIMARY) begin
            next_st.prdata[11:0] = {st.logical_error_capture_route, st.port_write_in_route,
                                    st.multicast_symbol_route};
         end else if (paddr_in == `IRP_OFS_PORT_ERR) begin
            next_st.prdata[15:0] = st.link_error_route;
         end else if (paddr_in == `IRP_OFS_RESET_EVT) begin
            next_st.prdata[3:0] = st.device_reset_route;
         end else begin
            next_st.pslverr = 1'b1;
         end
         if (pwrite_in) begin
            next_st.prdata = 32'h0;
         end
      end
      // Decode writes fall through untouched: the words are pure status
      if (wr_commit && aligned) begin
         if (paddr_in == `IRP_OFS_EVT_PRIMARY) begin
            next_st.logical_error_capture_route = pwdata_in[`IRP_LSB_LOGIC_ERR +: 4];
            next_st.port_write_in_route = pwdata_in[`IRP_LSB_PORT_WRITE +: 4];
            next_st.multicast_symbol_route = pwdata_in[`IRP_LSB_MULTICAST +: 4];
         end else if (paddr_in == `IRP_OFS_PORT_ERR) begin
            for (int p = 0; p < `IRP_NUM_LINK; p++) begin
               next_st.link_error_route[p] = pwdata_in[4 * p +: 4];
            end
         end else if (paddr_in == `IRP_OFS_RESET_EVT) begin
            next_st.device_reset_route = pwdata_in[`IRP_LSB_DEV_RESET +: 4];
         end
      end
   end

   // All fields reset to destination 0
   always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st <= '{logical_error_capture_route: `IRP_ROUTE_RST,
                 port_write_in_route: `IRP_ROUTE_RST,
                 multicast_symbol_route: `IRP_ROUTE_RST,
                 link_error_route: {`IRP_NUM_LINK{`IRP_ROUTE_RST}},
                 device_reset_route: `IRP_ROUTE_RST,
                 prdata: 32'h0,
                 pready: 1'b0,
                 pslverr: 1'b0,
                 pulse: 8'h0};
      end else begin
         st <= next_st;
      end
   end

   assign prdata_out = st.prdata;
   assign pready_out = st.pready;
   assign pslverr_out = st.pslverr;
   assign physical_destination_out = st.pulse;

   a_logic_err_route: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      wr_commit && paddr_in == `IRP_OFS_EVT_PRIMARY
      |=> st.logical_error_capture_route == $past(pwdata_in[11:8]))
      else $error("logical error field not written from bits 11-8");
   a_port_write_route: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      (condition_status_bits_in[`IRP_SRC_PORT_WRITE] && !st.port_write_in_route[3])
      |-> destination_decode_bits[st.port_write_in_route[2:0]][`IRP_DEC_PORT_WRITE])
      else $error("port-write source missing from its destination");
   a_multicast_route: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      wr_commit && paddr_in == `IRP_OFS_EVT_PRIMARY ##1 condition_status_bits_in[`IRP_SRC_MULTICAST]
      && !$past(pwdata_in[3]) |-> destination_decode_bits[$past(pwdata_in[2:0])][`IRP_DEC_MULTICAST])
      else $error("multicast source not routed by bits 3-0");
   a_link3_route: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      wr_commit && paddr_in == `IRP_OFS_PORT_ERR
      |=> st.link_error_route[3] == $past(pwdata_in[15:12]) && st.link_error_route[0] == $past(pwdata_in[3:0]))
      else $error("link error fields misplaced");
   a_reset_reserved: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      setup_phase && !pwrite_in && paddr_in == `IRP_OFS_RESET_EVT
      |=> prdata_out[31:4] == 28'h0 && prdata_out[3:0] == st.device_reset_route)
      else $error("reset routing readback wrong");
   a_decode_exclusive: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      destination_decode_bits[0][`IRP_DEC_LOGIC_ERR]
      |-> st.logical_error_capture_route == 4'h0 && condition_status_bits_in[`IRP_SRC_LOGIC_ERR])
      else $error("unrouted source seen in decode word");
   a_decode_read: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      setup_phase && !pwrite_in && bank == `IRP_BANK_DECODE && aligned
      |=> prdata_out == $past(destination_decode_bits[word_sel]) && pready_out)
      else $error("decode readback wrong");
   a_pacing_load: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      pace_hit |=> pace_count[$past(wr_dest)] == $past(pwdata_in))
      else $error("pacing write did not reload counter");
   a_decode_ro: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      wr_commit && bank == `IRP_BANK_DECODE
      |=> $stable(st.link_error_route) && $stable(st.device_reset_route) && $stable(st.multicast_symbol_route))
      else $error("decode write changed routing state");
   a_pulse_out: assert property (@(posedge sys_clk_in) disable iff (!rst_sync_n)
      $rose(pace_pulse[0]) |=> physical_destination_out[0] ##1 !physical_destination_out[0])
      else $error("destination 0 pulse not one cycle");
endmodule

// *** tb/interrupt_routing_pacing_tb.sv ***
// Self-checking bench for the router: routing registers, decode words and pulse pacing over APB.
// Assumes the router answers APB with pready and pulses each destination one cycle wide.
`timescale 1ns/1ps
module interrupt_routing_pacing_tb;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, long_pulse;
   logic [7:0] paddr, cond, dest, c0;
   logic [31:0] pwdata, prdata, rd, r_prim, r_port, r_rst, n_val;
   logic [7:0][7:0] pcount;
   logic [2:0] d;
   int seed, fails, num_checks;

   irp_top i_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .condition_status_bits_in(cond), .physical_destination_out(dest));
   irp_cpu_model i_cpu (.clk_in(sys_clk), .pulse_in(dest), .pulse_count_out(pcount),
      .long_pulse_out(long_pulse));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Entered right after a rising edge; the idle edge at the end keeps drivers single per step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // Request stands until the rising edge at which pready is seen high
      while (pready !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 20) begin
         fails++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      check({32'h0, rd}, {32'h0, exp});
      check({63'h0, err}, {63'h0, exp_err});
   endtask

   task automatic set_routes(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      wr(8'h00, a);
      wr(8'h04, b);
      wr(8'h08, c);
      r_prim = a & 32'h0000_0fff;
      r_port = b & 32'h0000_ffff;
      r_rst = c & 32'h0000_000f;
   endtask

   function automatic logic [31:0] exp_dec(input int k);
      logic [31:0] v;
      v = '0;
      v[0] = cond[0] && r_prim[3:0] == k;
      v[1] = cond[1] && r_prim[7:4] == k;
      v[2] = cond[2] && r_prim[11:8] == k;
      for (int p = 0; p < 4; p++) begin
         v[8 + p] = cond[3 + p] && r_port[4 * p +: 4] == k;
      end
      v[16] = cond[7] && r_rst[3:0] == k;
      return v;
   endfunction

   initial begin
      seed = 7332;
      fails = 0;
      num_checks = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cond = 8'h00;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      for (int a = 0; a < 'h60; a += 4) begin
         rdc(8'(a), 32'h0, (a >= 'h0c && a < 'h20));
      end
      rdc(8'h02, 32'h0, 1'b1);
      rdc(8'hfc, 32'h0, 1'b1);
      // Counters leave reset armed, so the first pending level fires destination 0 once
      cond <= 8'($random(seed)) | 8'h01;
      repeat (30) @(posedge sys_clk);
      check(pcount, 64'h1);
      for (int i = 0; i < 8; i++) begin
         set_routes($random(seed), $random(seed), $random(seed));
         cond <= 8'($random(seed));
         rdc(8'h00, r_prim, 1'b0);
         rdc(8'h04, r_port, 1'b0);
         rdc(8'h08, r_rst, 1'b0);
         for (int k = 0; k < 8; k++) begin
            wr(8'h20 + 8'(4 * k), $random(seed));
            rdc(8'h20 + 8'(4 * k), exp_dec(k), 1'b0);
         end
      end
      for (int i = 0; i < 6; i++) begin
         d = 3'($random(seed));
         n_val = (i < 2) ? 32'h0 : (i == 2) ? 32'h1 : 32'h8 + 32'($random(seed) & 63);
         cond <= 8'h00;
         set_routes({20'h0, {3{1'b0, d}}}, {16'h0, {4{1'b0, d}}}, {28'h0, 1'b0, d});
         wr(8'h40 + {3'h0, d, 2'b00}, n_val);
         c0 = pcount[d];
         cond <= 8'($random(seed)) | 8'h01;
         if (n_val > 1) repeat (n_val - 2) @(posedge sys_clk);
         check({56'h0, pcount[d]}, {56'h0, c0});
         repeat (12) @(posedge sys_clk);
         check({56'h0, pcount[d]}, {56'h0, c0 + 8'h01});
         repeat (20) @(posedge sys_clk);
         check({56'h0, pcount[d]}, {56'h0, c0 + 8'h01});
         rdc(8'h40 + {3'h0, d, 2'b00}, 32'h0, 1'b0);
      end
      n_val = {12'hff0, 20'($random(seed))};
      wr(8'h5c, n_val);
      apb(1'b0, 8'h5c, 32'h0);
      check({63'h0, rd <= n_val && rd + 32'h8 > n_val}, 64'h1);
      check({63'h0, long_pulse}, 64'h0);
      complete_run();
   end
endmodule

// *** tb/irp_cpu_model.sv ***
// Far-side model: the CPU interrupt inputs, counting pulses per destination.
// Assumes pulses are synchronous to the router clock.
`timescale 1ns/1ps
module irp_cpu_model (
   input wire logic clk_in,
   input wire logic [7:0] pulse_in,
   output logic [7:0][7:0] pulse_count_out,
   output logic long_pulse_out
);
   logic [7:0] last_pulse = 8'h00;
   logic [7:0][7:0] pulse_count = '0;
   logic long_pulse = 1'b0;
   always @(posedge clk_in) begin
      for (int i = 0; i < 8; i++) begin
         if (pulse_in[i] === 1'b1) begin
            pulse_count[i] <= pulse_count[i] + 8'h01;
         end
      end
      // Edge-triggered CPU inputs would see a held level as one event, so flag it
      if (|(pulse_in & last_pulse) === 1'b1) begin
         long_pulse <= 1'b1;
      end
      last_pulse <= pulse_in;
   end
   assign pulse_count_out = pulse_count;
   assign long_pulse_out = long_pulse;
endmodule
